/* File: design/cit_defs.vh */
// constants for the instruction timing and operand addressing core
// assumes a single 50 MHz core clock and byte-wide instruction fields
`ifndef CIT_DEFS_VH
`define CIT_DEFS_VH

// ------------------------------------------------------------
// opcode groups (upper nibble) of the arithmetic set
// ------------------------------------------------------------
`define CIT_GRP_INC        4'h0
`define CIT_GRP_DEC        4'h1
`define CIT_GRP_ADD        4'h2
`define CIT_GRP_ADD_WITH_CARRY       4'h3
`define CIT_GRP_SUBTRACT_WITH_BORROW       4'h9

// ------------------------------------------------------------
// single opcodes
// ------------------------------------------------------------
`define CIT_OP_INC_DATA_POINTER    8'hA3
`define CIT_OP_MUL         8'hA4
`define CIT_OP_DIV         8'h84
`define CIT_OP_DA          8'hD4
`define CIT_OP_SJMP        8'h80
`define CIT_OP_LJMP        8'h02
`define CIT_OP_LCALL       8'h12
`define CIT_OP_DJNZ_DIR    8'hD5

// ------------------------------------------------------------
// operand addressing modes
// ------------------------------------------------------------
`define CIT_MODE_NONE      3'h0
`define CIT_MODE_ACC       3'h1
`define CIT_MODE_REG       3'h2
`define CIT_MODE_DIR       3'h3
`define CIT_MODE_IND       3'h4
`define CIT_MODE_IMM       3'h5

// ------------------------------------------------------------
// clock counts per instruction form
// ------------------------------------------------------------
`define CIT_CLK_ALU_REG    5'h04
`define CIT_CLK_ALU_IND    5'h05
`define CIT_CLK_ALU_DIR    5'h06
`define CIT_CLK_ID_ACC     5'h03
`define CIT_CLK_ID_REG     5'h04
`define CIT_CLK_ID_IND     5'h05
`define CIT_CLK_ID_DIR     5'h07
`define CIT_CLK_INC_DATA_POINTER   5'h06
`define CIT_CLK_MUL        5'h0F
`define CIT_CLK_DIV        5'h12
`define CIT_CLK_DA         5'h0C

// ------------------------------------------------------------
// address layout
// ------------------------------------------------------------
`define CIT_SFR_BIT        7
`define CIT_PAGE_MSB       15
`define CIT_PAGE_LSB       11

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CIT_RST_BYTE       8'h00
`define CIT_RST_WORD       16'h0000

`endif

/* File: design/cit_core.v */
// arithmetic execution, operand addressing and branch targets of the core
// assumes the memory side returns operand_data before the last busy cycle
// and that every input comes from logic on the same clock
`timescale 1ns/1ps
`include "cit_defs.vh"

module cit_core
(
    // clock and reset
    input  wire        clk,
    input  wire        srst,
    // instruction in
    input  wire        instr_valid,
    input  wire [7:0]  opcode,
    input  wire [7:0]  op_byte1,
    input  wire [7:0]  op_byte2,
    input  wire [15:0] next_pc,
    // register file context
    input  wire [1:0]  bank_sel,
    input  wire [7:0]  r0_value,
    input  wire [7:0]  r1_value,
    input  wire [7:0]  operand_data,
    // state load from other groups
    input  wire        load_en,
    input  wire [7:0]  load_acc,
    input  wire [7:0]  load_b,
    input  wire [15:0] load_data_pointer,
    input  wire        load_cy,
    // sequencing out
    output wire        busy_out,
    output wire        instr_done,
    output reg         instr_supported,
    output reg  [1:0]  instr_length,
    output reg  [4:0]  instr_clocks,
    // operand access out
    output reg  [7:0]  operand_addr,
    output reg         operand_is_sfr,
    output wire        operand_rd,
    output reg         wb_en,
    output reg  [7:0]  wb_addr,
    output reg  [7:0]  wb_data,
    // branch target out
    output reg  [15:0] branch_target,
    output reg  [7:0]  bit_addr,
    // architectural state out
    output reg  [7:0]  acc,
    output reg  [7:0]  b_reg,
    output reg  [15:0] data_pointer,
    output reg         cy,
    output reg         ac,
    output reg         ov
);

// ------------------------------------------------------------
// decode functions
// ------------------------------------------------------------

// addressing mode of an arithmetic opcode
function [2:0] cit_mode;
    input [7:0] op;
    begin
        if (op[3])
            cit_mode = `CIT_MODE_REG;
        else if (op[3:1] == 3'h3)
            cit_mode = `CIT_MODE_IND;
        else if (op[3:0] == 4'h5)
            cit_mode = `CIT_MODE_DIR;
        else if (op[3:0] == 4'h4)
            cit_mode = (op[7:5] == 3'h0) ? `CIT_MODE_ACC : `CIT_MODE_IMM;
        else
            cit_mode = `CIT_MODE_NONE;
    end
endfunction

// true for the add, add_with_carry and subtract_with_borrow groups
function cit_is_alu;
    input [7:0] op;
    begin
        cit_is_alu = (op[7:4] == `CIT_GRP_ADD || op[7:4] == `CIT_GRP_ADD_WITH_CARRY
                      || op[7:4] == `CIT_GRP_SUBTRACT_WITH_BORROW) && (op[3:0] >= 4'h4);
    end
endfunction

// true for increment and decrement of byte operands
function cit_is_incdec;
    input [7:0] op;
    begin
        cit_is_incdec = (op[7:4] == `CIT_GRP_INC || op[7:4] == `CIT_GRP_DEC)
                        && (op[3:0] >= 4'h4);
    end
endfunction

// fixed clock count, from the opcode alone
function [4:0] cit_clocks;
    input [7:0] op;
    begin
        cit_clocks = 5'h00;
        if (op == `CIT_OP_INC_DATA_POINTER)
            cit_clocks = `CIT_CLK_INC_DATA_POINTER;
        else if (op == `CIT_OP_MUL)
            cit_clocks = `CIT_CLK_MUL;
        else if (op == `CIT_OP_DIV)
            cit_clocks = `CIT_CLK_DIV;
        else if (op == `CIT_OP_DA)
            cit_clocks = `CIT_CLK_DA;
        else if (cit_is_alu(op))
            case (cit_mode(op))
                `CIT_MODE_REG: cit_clocks = `CIT_CLK_ALU_REG;
                `CIT_MODE_IND: cit_clocks = `CIT_CLK_ALU_IND;
                default:       cit_clocks = `CIT_CLK_ALU_DIR;
            endcase
        else if (cit_is_incdec(op))
            case (cit_mode(op))
                `CIT_MODE_ACC: cit_clocks = `CIT_CLK_ID_ACC;
                `CIT_MODE_REG: cit_clocks = `CIT_CLK_ID_REG;
                `CIT_MODE_IND: cit_clocks = `CIT_CLK_ID_IND;
                default:       cit_clocks = `CIT_CLK_ID_DIR;
            endcase
    end
endfunction

// byte length of the arithmetic and branch opcodes handled here
function [1:0] cit_length;
    input [7:0] op;
    begin
        if (op == `CIT_OP_LJMP || op == `CIT_OP_LCALL || op == `CIT_OP_DJNZ_DIR
            || op == 8'h10 || op == 8'h20 || op == 8'h30
            || (op[7:4] == 4'hB && op[3:2] != 2'h0))
            cit_length = 2'h3;
        else if (op[3:0] == 4'h1 || op == `CIT_OP_SJMP
                 || (op[3:0] == 4'h0 && op[7:6] == 2'h1)
                 || (op[7:3] == 5'h1B)
                 || (op[3:0] == 4'h4 && cit_is_alu(op))
                 || op[3:0] == 4'h5)
            cit_length = 2'h2;
        else
            cit_length = 2'h1;
    end
endfunction

// ------------------------------------------------------------
// sequencing state
// ------------------------------------------------------------
reg        busy;          // instruction in execution
reg  [4:0] cnt;           // clocks left after this one
reg  [7:0] op_q;          // opcode under execution
reg  [7:0] imm_q;         // immediate byte held
reg  [2:0] mode_q;        // addressing mode held

// start accepted only while idle
wire       start    = instr_valid & ~busy;
wire [4:0] clk_n    = cit_clocks(opcode);
wire [2:0] mode_n   = cit_mode(opcode);
wire [7:0] ri_value = opcode[0] ? r1_value : r0_value;
// relative offset byte sits last in the instruction
wire [7:0] rel_byte = (cit_length(opcode) == 2'h3) ? op_byte2 : op_byte1;

assign busy_out   = busy;
assign instr_done = busy & (cnt == 5'h00);
assign operand_rd = busy & (mode_q == `CIT_MODE_REG || mode_q == `CIT_MODE_DIR
                            || mode_q == `CIT_MODE_IND);

// ------------------------------------------------------------
// decode capture and clock counter
// ------------------------------------------------------------
always @(posedge clk)
begin
    if (srst)
    begin
        busy            <= 1'b0;
        cnt             <= 5'h00;
        op_q            <= `CIT_RST_BYTE;
        imm_q           <= `CIT_RST_BYTE;
        mode_q          <= `CIT_MODE_NONE;
        instr_supported <= 1'b0;
        instr_length    <= 2'h1;
        instr_clocks    <= 5'h00;
        operand_addr    <= `CIT_RST_BYTE;
        operand_is_sfr  <= 1'b0;
        branch_target   <= `CIT_RST_WORD;
        bit_addr        <= `CIT_RST_BYTE;
    end
    else if (start)
    begin
        busy            <= (clk_n != 5'h00);
        cnt             <= clk_n - 5'h01;
        op_q            <= opcode;
        imm_q           <= op_byte1;
        mode_q          <= mode_n;
        instr_supported <= (clk_n != 5'h00);
        instr_length    <= cit_length(opcode);
        instr_clocks    <= clk_n;
        bit_addr        <= op_byte1;
        operand_is_sfr  <= (mode_n == `CIT_MODE_DIR) & op_byte1[`CIT_SFR_BIT];
        case (mode_n)
            `CIT_MODE_REG: operand_addr <= {3'h0, bank_sel, opcode[2:0]};
            // direct address taken as given
            `CIT_MODE_DIR: operand_addr <= op_byte1;
            `CIT_MODE_IND: operand_addr <= ri_value;
            default:       operand_addr <= `CIT_RST_BYTE;
        endcase
        // branch target forms
        if (opcode == `CIT_OP_LJMP || opcode == `CIT_OP_LCALL)
            branch_target <= {op_byte1, op_byte2};
        else if (opcode[3:0] == 4'h1)
            branch_target <= {next_pc[`CIT_PAGE_MSB:`CIT_PAGE_LSB],
                              opcode[7:5], op_byte1};
        else
            branch_target <= next_pc + {{8{rel_byte[7]}}, rel_byte};
    end
    else if (busy)
    begin
        // count down; finish on zero
        if (cnt == 5'h00)
            busy <= 1'b0;
        else
            cnt  <= cnt - 5'h01;
    end
end

// ------------------------------------------------------------
// arithmetic results, formed for the final cycle
// ------------------------------------------------------------
reg  [7:0]  src;          // second operand
reg  [8:0]  sum;          // byte result with carry
reg  [4:0]  nib;          // low nibble result
reg  [7:0]  id_val;       // increment or decrement value
reg  [15:0] prod;         // multiply product
reg  [8:0]  da_lo;        // decimal adjust, low step
reg  [8:0]  da_hi;        // decimal adjust, high step
reg         cin;          // carry in for the group

always @*
begin
    src    = (mode_q == `CIT_MODE_IMM) ? imm_q : operand_data;
    cin    = (op_q[7:4] == `CIT_GRP_ADD) ? 1'b0 : cy;
    if (op_q[7:4] == `CIT_GRP_SUBTRACT_WITH_BORROW)
    begin
        sum = {1'b0, acc} - {1'b0, src} - {8'h00, cin};
        nib = {1'b0, acc[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
    end
    else
    begin
        sum = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
        nib = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    end
    id_val = (mode_q == `CIT_MODE_ACC) ? acc : operand_data;
    id_val = op_q[4] ? id_val - 8'h01 : id_val + 8'h01;
    prod   = acc * b_reg;
    da_lo  = (acc[3:0] > 4'h9 || ac) ? {1'b0, acc} + 9'h006 : {1'b0, acc};
    da_hi  = (da_lo[7:4] > 4'h9 || cy || da_lo[8]) ? {1'b0, da_lo[7:0]} + 9'h060
                                                    : {1'b0, da_lo[7:0]};
end

// ------------------------------------------------------------
// architectural state and write back
// ------------------------------------------------------------
always @(posedge clk)
begin
    if (srst)
    begin
        acc          <= `CIT_RST_BYTE;
        b_reg        <= `CIT_RST_BYTE;
        data_pointer <= `CIT_RST_WORD;
        cy           <= 1'b0;
        ac           <= 1'b0;
        ov           <= 1'b0;
        wb_en        <= 1'b0;
        wb_addr      <= `CIT_RST_BYTE;
        wb_data      <= `CIT_RST_BYTE;
    end
    else
    begin
        wb_en <= 1'b0;
        if (instr_done)
        begin
            if (op_q == `CIT_OP_INC_DATA_POINTER)
                data_pointer <= data_pointer + 16'h0001;
            else if (op_q == `CIT_OP_MUL)
            begin
                acc   <= prod[7:0];
                b_reg <= prod[15:8];
                cy    <= 1'b0;
                ov    <= (prod[15:8] != 8'h00);
            end
            else if (op_q == `CIT_OP_DIV)
            begin
                // divide by zero leaves acc and b alone
                cy <= 1'b0;
                ov <= (b_reg == 8'h00);
                if (b_reg != 8'h00)
                begin
                    acc   <= acc / b_reg;
                    b_reg <= acc % b_reg;
                end
            end
            else if (op_q == `CIT_OP_DA)
            begin
                acc <= da_hi[7:0];
                cy  <= cy | da_lo[8] | da_hi[8];
            end
            else if (cit_is_alu(op_q))
            begin
                acc <= sum[7:0];
                cy  <= sum[8];
                ac  <= nib[4];
                ov  <= (op_q[7:4] == `CIT_GRP_SUBTRACT_WITH_BORROW) ? (acc[7] ^ src[7]) & (acc[7] ^ sum[7])
                                                     : ~(acc[7] ^ src[7]) & (acc[7] ^ sum[7]);
            end
            else if (mode_q == `CIT_MODE_ACC)
                acc <= id_val;
            else
            begin
                // byte increment and decrement write to memory
                wb_en   <= 1'b1;
                wb_addr <= operand_addr;
                wb_data <= id_val;
            end
        end
        else if (load_en & ~busy)
        begin
            // state loaded by other instruction groups
            acc          <= load_acc;
            b_reg        <= load_b;
            data_pointer <= load_data_pointer;
            cy           <= load_cy;
        end
    end
end

endmodule // cit_core

/* File: dv/cit_core_checker.sv */
// concurrent checks on the arithmetic timing core ports
// assumes one clock domain and the cit_defs.vh opcode constants
`timescale 1ns/1ps
`include "cit_defs.vh"
module cit_core_checker
(
    // clock and reset
    input wire        clk,
    input wire        srst,
    // request side
    input wire        instr_valid,
    input wire [7:0]  opcode,
    input wire [7:0]  op_byte1,
    input wire [15:0] next_pc,
    // sequencing side
    input wire        busy_out,
    input wire        instr_done,
    input wire [4:0]  instr_clocks,
    input wire        wb_en,
    input wire [15:0] branch_target
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire       take = instr_valid && !busy_out; // request taken this edge
    reg  [4:0] cyc;                             // busy cycles before this one
    reg [15:0] pg_tgt;                          // page target from take cycle
    // count busy cycles of the running instruction
    always @(posedge clk)
    begin
        if (srst || instr_done)
            cyc <= 5'h00;
        else if (busy_out)
            cyc <= cyc + 5'h01;
        pg_tgt <= {next_pc[15:11], opcode[7:5], op_byte1};
    end
    property p_count;
        instr_done |-> cyc == instr_clocks - 5'h01;
    endproperty
    a_count: assert property (p_count) else $error("done not in last counted cycle");
    property p_add_reg;
        take && opcode[7:3] == 5'h05 |-> ##4 instr_done;
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("register add count wrong");
    property p_add_imm;
        take && opcode == 8'h24 |-> ##6 instr_done;
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("immediate add count wrong");
    property p_data_pointer;
        take && opcode == `CIT_OP_INC_DATA_POINTER |-> ##6 instr_done;
    endproperty
    a_data_pointer: assert property (p_data_pointer) else $error("pointer increment count wrong");
    property p_mul;
        take && opcode == `CIT_OP_MUL |-> ##15 instr_done;
    endproperty
    a_mul: assert property (p_mul) else $error("multiply count wrong");
    property p_div;
        take && opcode == `CIT_OP_DIV |-> ##18 instr_done;
    endproperty
    a_div: assert property (p_div) else $error("divide count wrong");
    property p_da;
        take && opcode == `CIT_OP_DA |-> ##12 instr_done;
    endproperty
    a_da: assert property (p_da) else $error("decimal adjust count wrong");
    property p_wb;
        wb_en |-> $past(instr_done);
    endproperty
    a_wb: assert property (p_wb) else $error("write back not after done");
    property p_page;
        take && opcode[4:0] == 5'h01 |=> branch_target == pg_tgt;
    endproperty
    a_page: assert property (p_page) else $error("page target left its page");
endmodule // cit_core_checker
bind cit_core cit_core_checker u_chk
(
    .clk(clk), .srst(srst), .instr_valid(instr_valid), .opcode(opcode),
    .op_byte1(op_byte1), .next_pc(next_pc), .busy_out(busy_out),
    .instr_done(instr_done), .instr_clocks(instr_clocks), .wb_en(wb_en),
    .branch_target(branch_target)
);

/* File: dv/cit_mem_model.sv */
// internal data and special register store behind the operand port
// assumes reads are combinational while operand_rd is high
`timescale 1ns/1ps
module cit_mem_model
(
    // clock
    input wire       clk,
    // operand access
    input wire [7:0] operand_addr,
    input wire       operand_is_sfr,
    input wire       operand_rd,
    output wire [7:0] operand_data,
    // write back
    input wire       wb_en,
    input wire [7:0] wb_addr,
    input wire [7:0] wb_data
);
    reg [7:0] mem [0:255]; // data store, starts as inverted address
    reg [7:0] last;        // last driven byte
    integer   i;
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = ~i[7:0];
        last = 8'h00;
    end
    assign operand_data = !operand_rd ? ~last :
                          operand_is_sfr ? (operand_addr ^ 8'h3C) : mem[operand_addr];
    // hold last value, store write backs
    always @(posedge clk)
    begin
        last <= operand_data;
        if (wb_en)
            mem[wb_addr] <= wb_data;
    end
endmodule // cit_mem_model

/* File: dv/cit_core_tb_top.sv */
// self-checking bench for the arithmetic timing core
// assumes the design header cit_defs.vh and the memory model
`timescale 1ns/1ps
`include "cit_defs.vh"
module cit_core_tb_top;
    reg clk = 0, srst = 1, instr_valid = 0, load_en = 0, load_cy = 0;
    reg [7:0] opcode = 0, op_byte1 = 0, op_byte2 = 0, r0_value = 0, r1_value = 0;
    reg [7:0] load_acc = 0, load_b = 0;
    reg [15:0] next_pc = 0, load_data_pointer = 0, pc_q = 0;
    reg [1:0] bank_sel = 0;
    wire [7:0] operand_data, operand_addr, wb_addr, wb_data, bit_addr, acc, b_reg;
    wire [15:0] branch_target, data_pointer;
    wire [4:0] instr_clocks;
    wire [1:0] instr_length;
    wire busy_out, instr_done, instr_supported, operand_is_sfr, operand_rd, wb_en, cy, ac, ov;
    integer error_cnt = 0, num_checks = 0, cyc_cnt = 0, p;
    always #10 clk = ~clk;
    cit_core uut (.clk(clk), .srst(srst), .instr_valid(instr_valid), .opcode(opcode),
        .op_byte1(op_byte1), .op_byte2(op_byte2), .next_pc(next_pc), .bank_sel(bank_sel),
        .r0_value(r0_value), .r1_value(r1_value), .operand_data(operand_data),
        .load_en(load_en), .load_acc(load_acc), .load_b(load_b), .load_data_pointer(load_data_pointer),
        .load_cy(load_cy), .busy_out(busy_out), .instr_done(instr_done),
        .instr_supported(instr_supported), .instr_length(instr_length),
        .instr_clocks(instr_clocks), .operand_addr(operand_addr),
        .operand_is_sfr(operand_is_sfr), .operand_rd(operand_rd), .wb_en(wb_en),
        .wb_addr(wb_addr), .wb_data(wb_data), .branch_target(branch_target),
        .bit_addr(bit_addr), .acc(acc), .b_reg(b_reg), .data_pointer(data_pointer),
        .cy(cy), .ac(ac), .ov(ov));
    cit_mem_model u_mem (.clk(clk), .operand_addr(operand_addr),
        .operand_is_sfr(operand_is_sfr), .operand_rd(operand_rd),
        .operand_data(operand_data), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data));
    // verdict and end of run
    task complete_run;
    begin
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // compare one value
    task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    // run one instruction; n zero means not handled here
    task issue(input [7:0] op, input [7:0] b1, input [7:0] b2, input [4:0] n,
               input [1:0] len);
        integer k;
    begin
        @(posedge clk);
        opcode <= op; op_byte1 <= b1; op_byte2 <= b2; next_pc <= pc_q; instr_valid <= 1;
        @(posedge clk);
        instr_valid <= 0;
        #1;
        check(instr_supported, n != 5'h00);
        if (n != 0)
        begin
            check(instr_length, len);
            k = 1;
            while (instr_done !== 1'b1 && k < 40)
            begin
                @(posedge clk);
                #1 k = k + 1;
            end
            check(k, n);
            check(instr_clocks, n);
            @(posedge clk);
            #1;
        end
        else
            check(busy_out, 0);
    end
    endtask
    // load architectural state
    task load(input [7:0] a, input [7:0] b, input [15:0] d, input c);
    begin
        @(posedge clk);
        load_acc <= a; load_b <= b; load_data_pointer <= d; load_cy <= c; load_en <= 1;
        @(posedge clk);
        load_en <= 0;
    end
    endtask
    // clock counts of every arithmetic form, two operand sets
    task t_timing;
        integer g;
    begin
        for (p = 0; p < 2; p = p + 1)
        begin
            load(p ? 8'hFF : 8'h00, p ? 8'hFF : 8'h00, 16'hFFFF, p[0]);
            for (g = 0; g < 3; g = g + 1)
            begin
                issue({g == 2 ? 4'h9 : 4'h2 + g[3:0], 4'h8}, 0, 0, 4, 1);
                issue({g == 2 ? 4'h9 : 4'h2 + g[3:0], 4'h6}, 0, 0, 5, 1);
                issue({g == 2 ? 4'h9 : 4'h2 + g[3:0], 4'h5}, 8'h40, 0, 6, 2);
                issue({g == 2 ? 4'h9 : 4'h2 + g[3:0], 4'h4}, 8'h11, 0, 6, 2);
            end
            for (g = 0; g < 2; g = g + 1)
            begin
                issue({g[3:0], 4'h4}, 0, 0, 3, 1);
                issue({g[3:0], 4'h8}, 0, 0, 4, 1);
                issue({g[3:0], 4'h6}, 0, 0, 5, 1);
                issue({g[3:0], 4'h5}, 8'h50, 0, 7, 2);
            end
            issue(`CIT_OP_INC_DATA_POINTER, 0, 0, 6, 1);
            issue(`CIT_OP_MUL, 0, 0, 15, 1);
            issue(`CIT_OP_DIV, 0, 0, 18, 1);
            issue(`CIT_OP_DA, 0, 0, 12, 1);
        end
    end
    endtask
    // results equal to the classic set
    task t_results;
    begin
        load(8'h35, 8'h07, 16'h00FF, 0);
        issue(`CIT_OP_MUL, 0, 0, 15, 1);
        check({acc, b_reg}, 16'h7301);
        check({cy, ov}, 2'h1);
        issue(`CIT_OP_INC_DATA_POINTER, 0, 0, 6, 1);
        check(data_pointer, 16'h0100);
        load(8'hFB, 8'h10, 16'h0000, 0);
        issue(`CIT_OP_DIV, 0, 0, 18, 1);
        check({acc, b_reg}, 16'h0F0B);
        load(8'h56, 8'h00, 16'h0000, 0);
        issue(8'h24, 8'h67, 0, 6, 2);
        issue(`CIT_OP_DA, 0, 0, 12, 1);
        check({cy, acc}, 16'h0123);
        load(8'h10, 8'h00, 16'h0000, 1);
        issue(8'h94, 8'h05, 0, 6, 2);
        check({cy, ac, ov, acc}, 16'h020A);
        load(8'h7F, 8'h00, 16'h0000, 0);
        issue(8'h24, 8'h01, 0, 6, 2);
        check({cy, ac, ov, acc}, 16'h0380);
    end
    endtask
    // operand addresses, fetch and write back
    task t_addr;
    begin
        @(posedge clk);
        bank_sel <= 2'h2; r1_value <= 8'hC8;
        load(8'h00, 8'h00, 16'h0000, 0);
        issue(8'h2B, 0, 0, 4, 1);
        check({operand_is_sfr, operand_addr}, 16'h0013);
        issue(8'h27, 0, 0, 5, 1);
        check({operand_is_sfr, operand_addr}, 16'h00C8);
        issue(8'h25, 8'h90, 0, 6, 2);
        check({operand_is_sfr, operand_addr}, 16'h0190);
        load(8'h00, 8'h00, 16'h0000, 0);
        issue(8'h25, 8'h7F, 0, 6, 2);
        check({operand_is_sfr, acc}, 16'h0080);
        issue(8'h05, 8'h30, 0, 7, 2);
        check({wb_en, wb_addr, wb_data}, 17'h130D0);
        issue(8'h17, 0, 0, 5, 1);
        check({wb_en, wb_addr, wb_data}, 17'h1C836);
    end
    endtask
    // branch and bit targets of opcodes handled elsewhere
    task t_branch;
    begin
        issue(`CIT_OP_LJMP, 8'h12, 8'h34, 0, 0);
        check(branch_target, 16'h1234);
        pc_q = 16'h37FE;
        issue(8'h61, 8'h45, 0, 0, 0);
        check(branch_target, 16'h3345);
        pc_q = 16'h1000;
        issue(`CIT_OP_SJMP, 8'hFE, 0, 0, 0);
        check(branch_target, 16'h0FFE);
        pc_q = 16'h2000;
        issue(`CIT_OP_DJNZ_DIR, 8'h40, 8'h10, 0, 0);
        check(branch_target, 16'h2010);
        issue(8'h20, 8'h93, 8'h05, 0, 0);
        check(bit_addr, 16'h0093);
    end
    endtask
    // cut a hang short
    always @(posedge clk)
    begin
        cyc_cnt = cyc_cnt + 1;
        if (cyc_cnt == 8000)
        begin
            error_cnt = error_cnt + 1;
            complete_run;
        end
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 0;
        #1 check({busy_out, instr_length, acc}, 16'h0100);
        t_timing;
        t_results;
        t_addr;
        t_branch;
        complete_run;
    end
endmodule // cit_core_tb_top
